/* File: core/sram_pkg.sv */
// Functional notes
// - selected load with write high starts read
// - advance during read steps burst address
// - read start with output enable high: dummy
// - read continue, enable high: advance, no drive
// - selected load with write low starts write
// - advance during write steps and accepts data
// - write start, no lanes: abort, nothing written
// - write continue, no lanes: advance, no write
// - qualifier high ignores edge, holds all but sleep entry
// - write cycles never drive data pins
// - output enable asynchronous, masked in writes
// - read drives pins only enabled and selected
// - power-up deselected, pins released
// - lane written when its select and write low
// - sleep releases pins, two cycles in/out
// - burst order linear or interleaved, wraps four
// - write data latched on next qualified edge
package sram_pkg;

    localparam int ADDR_W    = 17;
    localparam int DQ_W      = 18;
    localparam int LANE_W    = 9;
    localparam int LANES     = 2;
    localparam int BURST_W   = 2;
    localparam int MEM_WORDS = 1 << ADDR_W;
    localparam int FIFO_DEPTH = 16;
    localparam int CMD_W     = 1 + ADDR_W + LANES + DQ_W;

    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [LANES-1:0]   LANES_OFF  = 2'h3;
    localparam logic [DQ_W-1:0]    DQ_ZERO    = 18'h00000;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DQ_W-1:0]   dq_t;
    typedef logic [LANES-1:0]  lanes_t;

    typedef enum logic [3:0] {
        ST_DESEL = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_SLEEP = 4'h8
    } cyc_t;

endpackage

/* File: core/sram_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sram_bus_if;
    import sram_pkg::*;

    logic   clk_qualify_n;
    logic   chip_sel1_n;
    logic   chip_sel2;
    logic   chip_sel3_n;
    logic   advance_load_n;
    logic   wrEnN;
    lanes_t lane_wr_sel_n;
    logic   outEnN;
    logic   sleep_req;
    logic   burstInterleave;
    addr_t  addr;
    dq_t    hostDq;
    logic   hostDqOeN;
    dq_t    devDq;
    logic   devDqOeN;
    dq_t    dqBus;

    // shared data wire: whichever end enables drives, else reads zero
    assign dqBus = !devDqOeN  ? devDq  :
                   !hostDqOeN ? hostDq : DQ_ZERO;

    modport host (
        output clk_qualify_n, chip_sel1_n, chip_sel2, chip_sel3_n,
        output advance_load_n, wrEnN, lane_wr_sel_n, outEnN,
        output sleep_req, burstInterleave, addr, hostDq, hostDqOeN,
        input  dqBus
    );

    modport dev (
        input  clk_qualify_n, chip_sel1_n, chip_sel2, chip_sel3_n,
        input  advance_load_n, wrEnN, lane_wr_sel_n, outEnN,
        input  sleep_req, burstInterleave, addr, dqBus,
        output devDq, devDqOeN
    );

endinterface
`default_nettype wire

/* File: core/sram_device.sv */
`timescale 1ns/100ps
`default_nettype none
module sram_device (
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    sram_bus_if.dev        bus,
    output var  sram_pkg::cyc_t cycState,
    output logic           asleep
);
    import sram_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    cyc_t                state_r;
    cyc_t                state_nxt;
    logic                sleepMeta_r;
    logic                sleepSync_r;
    logic                asleep_r;
    logic [ADDR_W-1:2]   base_r;
    logic [BURST_W-1:0]  start_r;
    logic [BURST_W-1:0]  cnt_r;
    logic                mode_r;
    dq_t                 rdData_r;
    logic                rdDrive_r;
    logic                wrPend_r;
    addr_t               wrAddr_r;
    lanes_t              wrLanes_r;
    dq_t                 mem [0:MEM_WORDS-1];

    // ==========================================================
    // cycle decode
    // ==========================================================
    wire selected  = !bus.chip_sel1_n && bus.chip_sel2 &&
                     !bus.chip_sel3_n;
    wire qual      = !bus.clk_qualify_n;
    wire sleeping  = sleepSync_r;
    wire active    = qual && !sleeping;
    wire load      = active && !bus.advance_load_n;
    wire adv       = active && bus.advance_load_n;
    wire startRd   = load && selected && bus.wrEnN;
    wire startWr   = load && selected && !bus.wrEnN;
    wire inRead    = state_r == ST_READ;
    wire inWrite   = state_r == ST_WRITE;
    wire contRd    = adv && inRead;
    wire contWr    = adv && inWrite;

    // ==========================================================
    // burst counter
    // ==========================================================
    wire [BURST_W-1:0] nextCnt = cnt_r + BURST_ONE;
    wire [BURST_W-1:0] linLow  = start_r + nextCnt;
    wire [BURST_W-1:0] intLow  = start_r ^ nextCnt;
    // low address bits wrap inside a group of four
    wire [BURST_W-1:0] advLow  = mode_r ? intLow : linLow;
    wire addr_t        advAddr = {base_r, advLow};
    wire addr_t        accAddr = load ? bus.addr : advAddr;

    // write abort keeps both lane selects high, so nothing lands
    wire lanes_t wrLanesNxt = ~bus.lane_wr_sel_n;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        if (sleeping) begin
            state_nxt = ST_SLEEP;
        end else if (load) begin
            // a load on the wake-up edge must not be lost to the exit
            if (!selected) begin
                state_nxt = ST_DESEL;
            end else if (bus.wrEnN) begin
                state_nxt = ST_READ;
            end else begin
                state_nxt = ST_WRITE;
            end
        end else if (state_r == ST_SLEEP) begin
            state_nxt = ST_DESEL;
        end
        // advance keeps the latched operation, deselect included
    end

    // ==========================================================
    // sleep input crossing
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepMeta_r <= 1'b0;
            sleepSync_r <= 1'b0;
            asleep_r    <= 1'b0;
        end else begin
            sleepMeta_r <= bus.sleep_req;
            sleepSync_r <= sleepMeta_r;
            asleep_r    <= sleepSync_r;
        end
    end

    // ==========================================================
    // operation state
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_DESEL;
        end else if (qual || sleeping) begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // address register
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_r  <= '0;
            start_r <= BURST_ZERO;
            cnt_r   <= BURST_ZERO;
            mode_r  <= 1'b0;
        end else if (load) begin
            base_r  <= bus.addr[ADDR_W-1:2];
            start_r <= bus.addr[1:0];
            cnt_r   <= BURST_ZERO;
            mode_r  <= bus.burstInterleave;
        end else if (contRd || contWr) begin
            cnt_r   <= nextCnt;
        end
    end

    // ==========================================================
    // read path, flow-through from the loading edge
    // ==========================================================
    // a read taken on the edge that completes a write must see the
    // bytes that land on that same edge
    wire dq_t laneMask;
    for (genvar g = 0; g < LANES; g++) begin : gLaneMask
        assign laneMask[g*LANE_W +: LANE_W] = {LANE_W{wrLanes_r[g]}};
    end
    wire      wrHit   = active && wrPend_r &&
                        (wrAddr_r == accAddr);
    wire dq_t memWord = mem[accAddr];
    wire dq_t rdWord  = wrHit ? ((memWord & ~laneMask) |
                                 (bus.dqBus & laneMask)) : memWord;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= DQ_ZERO;
        end else if (startRd || contRd) begin
            rdData_r <= rdWord;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdDrive_r <= 1'b0;
        end else if (sleeping) begin
            rdDrive_r <= 1'b0;
        end else if (qual) begin
            // stall edges keep the current cycle's drive
            rdDrive_r <= startRd || contRd;
        end
    end

    // ==========================================================
    // write path: address now, data on the next qualified edge
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_r  <= 1'b0;
            wrAddr_r  <= '0;
            wrLanes_r <= '0;
        end else if (sleeping) begin
            wrPend_r  <= 1'b0;
        end else if (qual) begin
            wrPend_r  <= startWr || contWr;
            wrAddr_r  <= accAddr;
            wrLanes_r <= wrLanesNxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (active && wrPend_r) begin
            for (int i = 0; i < LANES; i++) begin
                if (wrLanes_r[i]) begin
                    mem[wrAddr_r][i*LANE_W +: LANE_W] <=
                        bus.dqBus[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ==========================================================
    // pin drivers
    // ==========================================================
    // output enable gates the drivers with no clock in the path;
    // the read flag is never set in a write cycle, which masks it
    assign bus.devDq    = rdData_r;
    assign bus.devDqOeN = !(rdDrive_r && !bus.outEnN);

    assign cycState = state_r;
    assign asleep   = asleep_r;

endmodule
`default_nettype wire

/* File: core/sram_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sram_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      cnt_r;
    logic             full_r;
    logic             empty_r;

    wire push = inValid && !full_r;
    wire pop  = outReady && !empty_r;
    wire [PW:0] cntNxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r   <= '0;
            full_r  <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            wrPtr_r <= wrPtr_r + PW'(push);
            rdPtr_r <= rdPtr_r + PW'(pop);
            cnt_r   <= cntNxt;
            full_r  <= cntNxt == FULL_CNT;
            empty_r <= cntNxt == '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    assign inReady  = !full_r;
    assign outValid = !empty_r;
    assign outData  = mem[rdPtr_r];
endmodule

module sram_host (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    sram_bus_if.host             bus,
    input  wire logic            cmdValid,
    output logic                 cmdReady,
    input  wire logic            cmdWrite,
    input  wire sram_pkg::addr_t cmdAddr,
    input  wire sram_pkg::lanes_t cmdLanesN,
    input  wire sram_pkg::dq_t   cmdData,
    input  wire logic            holdBus,
    input  wire logic            sleepIn,
    input  wire logic            burstModeIn,
    output logic                 rspValid,
    output sram_pkg::dq_t        rspData
);
    import sram_pkg::*;

    // ==========================================================
    // command queue
    // ==========================================================
    logic             qValid;
    logic [CMD_W-1:0] qData;
    wire  pop = qValid && !holdBus;

    sram_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) cmdQ (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .inValid  (cmdValid),
        .inReady  (cmdReady),
        .inData   ({cmdWrite, cmdAddr, cmdLanesN, cmdData}),
        .outValid (qValid),
        .outReady (pop),
        .outData  (qData)
    );

    wire    qWrite = qData[CMD_W-1];
    wire addr_t  qAddr  = qData[CMD_W-2 -: ADDR_W];
    wire lanes_t qLanes = qData[DQ_W +: LANES];
    wire dq_t    qWdata = qData[DQ_W-1:0];

    // ==========================================================
    // pin sequencer
    // ==========================================================
    logic   cqn_r, cs1n_r, ldn_r, wen_r, oen_r, slp_r, mode_r;
    lanes_t lanes_r;
    addr_t  addr_r;
    dq_t    wdat_r, dq_r;
    logic   dqOeN_r, rdAt_r, wrAt_r, rdWait_r;
    logic   rspValid_r;
    dq_t    rspData_r;

    // current pins are taken by the device on this edge
    wire taken = !cqn_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cqn_r  <= 1'b1;
            cs1n_r <= 1'b1;
            ldn_r  <= 1'b0;
            wen_r  <= 1'b1;
            lanes_r <= LANES_OFF;
            addr_r <= '0;
            wdat_r <= DQ_ZERO;
            rdAt_r <= 1'b0;
            wrAt_r <= 1'b0;
        end else if (holdBus) begin
            cqn_r  <= 1'b1;
        end else begin
            cqn_r  <= 1'b0;
            cs1n_r <= !pop;
            ldn_r  <= 1'b0;
            wen_r  <= !(pop && qWrite);
            lanes_r <= pop ? qLanes : LANES_OFF;
            addr_r <= qAddr;
            wdat_r <= qWdata;
            rdAt_r <= pop && !qWrite;
            wrAt_r <= pop && qWrite;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_r       <= DQ_ZERO;
            dqOeN_r    <= 1'b1;
            oen_r      <= 1'b1;
            rdWait_r   <= 1'b0;
            rspValid_r <= 1'b0;
            rspData_r  <= DQ_ZERO;
            slp_r      <= 1'b0;
            mode_r     <= 1'b0;
        end else begin
            slp_r      <= sleepIn;
            mode_r     <= burstModeIn;
            rspValid_r <= taken && rdWait_r;
            if (taken && rdWait_r) begin
                rspData_r <= bus.dqBus;
            end
            if (taken) begin
                rdWait_r <= rdAt_r;
                oen_r    <= !rdAt_r;
                dq_r     <= wdat_r;
                dqOeN_r  <= !wrAt_r;
            end
        end
    end

    assign bus.clk_qualify_n   = cqn_r;
    assign bus.chip_sel1_n     = cs1n_r;
    assign bus.chip_sel2       = 1'b1;
    assign bus.chip_sel3_n     = 1'b0;
    assign bus.advance_load_n  = ldn_r;
    assign bus.wrEnN           = wen_r;
    assign bus.lane_wr_sel_n   = lanes_r;
    assign bus.outEnN          = oen_r;
    assign bus.sleep_req       = slp_r;
    assign bus.burstInterleave = mode_r;
    assign bus.addr            = addr_r;
    assign bus.hostDq          = dq_r;
    assign bus.hostDqOeN       = dqOeN_r;
    assign rspValid            = rspValid_r;
    assign rspData             = rspData_r;
endmodule
`default_nettype wire

/* File: test/sram_cycle_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module sram_cycle_checker (
    input wire logic             sys_clk,
    input wire logic             rst_n,
    input wire logic             clk_qualify_n,
    input wire logic             chip_sel1_n,
    input wire logic             chip_sel2,
    input wire logic             chip_sel3_n,
    input wire logic             advance_load_n,
    input wire logic             wrEnN,
    input wire sram_pkg::lanes_t lane_wr_sel_n,
    input wire logic             outEnN,
    input wire logic             sleep_req,
    input wire logic             hostDqOeN,
    input wire logic             devDqOeN
);
    import sram_pkg::*;
    wire logic selected = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // cycle shapes
    sequence loadEdge;
        !clk_qualify_n && !advance_load_n;
    endsequence
    sequence awake3;
        !sleep_req [*3];
    endsequence
    sequence wrLoad;
        loadEdge ##0 (selected && !wrEnN);
    endsequence
    sequence rdLoad;
        awake3 ##0 loadEdge ##0 (selected && wrEnN);
    endsequence
    // ==========
    // pin ownership
    a_write_no_drive: assert property (wrLoad |=> devDqOeN)
        else $error("device drives pins after a write load");
    a_desel_release: assert property (
        loadEdge ##0 !selected |=> devDqOeN)
        else $error("device drives pins after a deselect");
    a_read_drives: assert property (
        rdLoad ##1 (!outEnN && !sleep_req) |-> !devDqOeN)
        else $error("read data not driven with output enabled");
    a_oe_masks: assert property (outEnN |-> devDqOeN)
        else $error("device drives pins with output disabled");
    a_no_contention: assert property (hostDqOeN || devDqOeN)
        else $error("both ends drive the data wire");
    a_sleep_release: assert property (sleep_req [*4] |-> devDqOeN)
        else $error("device drives pins while asleep");
    a_reset_release: assert property (
        $rose(rst_n) |-> devDqOeN && hostDqOeN)
        else $error("pins driven right after reset");
    a_stall_holds: assert property (
        awake3 ##0 clk_qualify_n ##1 $stable(outEnN) |-> $stable(devDqOeN))
        else $error("drive changed across an ignored edge");
    a_data_follows: assert property (
        wrLoad ##0 (lane_wr_sel_n != LANES_OFF) |=> !hostDqOeN)
        else $error("write data not presented after address");
endmodule
`default_nettype wire

/* File: test/test_flow_through_burst_sram_cycle_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_flow_through_burst_sram_cycle_control;
    import sram_pkg::*;
    logic       sys_clk;
    logic       rst_n;
    logic       cmdValid;
    logic       cmdReady;
    logic       cmdWrite;
    addr_t      cmdAddr;
    lanes_t     cmdLanesN;
    dq_t        cmdData;
    logic       holdBus;
    logic       sleepIn;
    logic       burstModeIn;
    logic       rspValid;
    dq_t        rspData;
    cyc_t       cycState;
    logic       asleep;
    int         fails;
    int         compares;
    int         cycles;
    dq_t        expQ[$];
    // second end codes: mode,qual,sel1,load,we,lanes,oe,hostOe
    logic [8:0] wrC [9] = '{9'h001, 9'h030, 9'h030, 9'h030, 9'h05c,
                            9'h001, 9'h03c, 9'h030, 9'h05c};
    logic [8:0] rdC [11] = '{9'h11d, 9'h13d, 9'h13d, 9'h1bd, 9'h13d,
                             9'h13d, 9'h15d, 9'h13d, 9'h11d, 9'h13f, 9'h13d};
    dq_t        rdE [11] = '{18'h0, 18'h16, 18'h14, 18'h18, 18'h18,
                             18'h12, 18'h16, 18'h0, 18'h0, 18'h0, 18'h14};

    sram_bus_if busA ();
    sram_bus_if busB ();
    sram_host u_sram_host (.sys_clk(sys_clk), .rst_n(rst_n), .bus(busA.host),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
        .cmdAddr(cmdAddr), .cmdLanesN(cmdLanesN), .cmdData(cmdData),
        .holdBus(holdBus), .sleepIn(sleepIn), .burstModeIn(burstModeIn),
        .rspValid(rspValid), .rspData(rspData));
    sram_device u_sram_device (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(busA.dev), .cycState(cycState), .asleep(asleep));
    sram_device u_sram_device_b (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(busB.dev), .cycState(), .asleep());
    sram_cycle_checker u_sram_cycle_checker (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_qualify_n(busA.clk_qualify_n),
        .chip_sel1_n(busA.chip_sel1_n), .chip_sel2(busA.chip_sel2),
        .chip_sel3_n(busA.chip_sel3_n), .advance_load_n(busA.advance_load_n),
        .wrEnN(busA.wrEnN), .lane_wr_sel_n(busA.lane_wr_sel_n),
        .outEnN(busA.outEnN), .sleep_req(busA.sleep_req),
        .hostDqOeN(busA.hostDqOeN), .devDqOeN(busA.devDqOeN));

    // ==========
    // tasks
    task automatic chk(input string name, input dq_t seen, input dq_t exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic w, input addr_t a, input lanes_t ln,
                       input dq_t d);
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdAddr <= a;
        cmdLanesN <= ln;
        cmdData <= d;
        @(posedge sys_clk);
        while (cmdReady !== 1'b1) @(posedge sys_clk);
    endtask
    task automatic rd(input addr_t a, input dq_t exp);
        expQ.push_back(exp);
        cmd(1'b0, a, LANES_OFF, DQ_ZERO);
    endtask
    task automatic drain();
        int n;
        n = 0;
        cmdValid <= 1'b0;
        while (expQ.size() != 0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk("pending", 18'(expQ.size()), 18'h0);
    endtask
    // one cycle on the second end, settled 10 ns after the edge
    task automatic bcyc(input logic [8:0] c, input addr_t a, input dq_t d);
        @(posedge sys_clk);
        {busB.burstInterleave, busB.clk_qualify_n, busB.chip_sel1_n,
         busB.advance_load_n, busB.wrEnN, busB.lane_wr_sel_n, busB.outEnN,
         busB.hostDqOeN} <= c;
        busB.addr <= a;
        busB.hostDq <= d;
        #10;
    endtask

    // ==========
    // clock, watchdog, response monitor
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    always @(posedge sys_clk) begin
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                fails++;
                $display("ERROR rspData exp none seen %h", rspData);
            end else begin
                chk("rspData", rspData, expQ.pop_front());
            end
        end
    end

    // ==========
    // main sequence
    initial begin
        rst_n = 1'b0;
        {cmdValid, cmdWrite, holdBus, sleepIn, burstModeIn} = 5'h00;
        {cmdAddr, cmdLanesN, cmdData} = '0;
        {busB.chip_sel2, busB.chip_sel3_n, busB.sleep_req} = 3'h4;
        {busB.burstInterleave, busB.clk_qualify_n, busB.chip_sel1_n,
         busB.advance_load_n, busB.wrEnN, busB.lane_wr_sel_n, busB.outEnN,
         busB.hostDqOeN} = 9'h05f;
        {busB.addr, busB.hostDq} = '0;
        repeat (12) @(posedge sys_clk);
        chk("cycState", 18'(cycState), 18'(ST_DESEL));
        chk("devDqOeN", 18'(busA.devDqOeN), 18'h1);
        rst_n <= 1'b1;
        cmd(1'b1, 17'h00010, 2'h0, 18'h3ffff);
        cmd(1'b1, 17'h00010, 2'h2, 18'h00000);
        rd(17'h00010, 18'h3fe00);
        cmd(1'b1, 17'h00010, 2'h1, 18'h2aaaa);
        rd(17'h00010, 18'h2aa00);
        cmd(1'b1, 17'h00010, 2'h3, 18'h00000);
        rd(17'h00010, 18'h2aa00);
        drain();
        holdBus <= 1'b1;
        burstModeIn <= 1'b1;
        for (int i = 0; i < 16; i++) rd(17'h00010, 18'h2aa00);
        cmdValid <= 1'b0;
        @(posedge sys_clk);
        #10;
        chk("cmdReady", 18'(cmdReady), 18'h0);
        chk("qualifyN", 18'(busA.clk_qualify_n), 18'h1);
        chk("burstPin", 18'(busA.burstInterleave), 18'h1);
        chk("pending", 18'(expQ.size()), 18'h10);
        @(posedge sys_clk);
        holdBus <= 1'b0;
        drain();
        sleepIn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("cycState", 18'(cycState), 18'(ST_SLEEP));
        chk("asleep", 18'(asleep), 18'h1);
        sleepIn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk("cycState", 18'(cycState), 18'(ST_DESEL));
        rd(17'h00010, 18'h2aa00);
        drain();
        foreach (wrC[i]) begin
            bcyc(wrC[i], 17'h00005, 18'h00010 + 18'(i));
            chk("devDqOeN", 18'(busB.devDqOeN), 18'h1);
        end
        foreach (rdC[i]) begin
            bcyc(rdC[i], 17'h00005, 18'h00000);
            chk("dqBus", busB.dqBus, rdE[i]);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
